// ### rtl/ptc_counter.sv
// one 16-bit up-counter with run, clear and one-shot stop
// assumes run/clear/oneshot come from the top as single-cycle write pulses or levels
`timescale 1ns/1ps
`default_nettype none
module ptc_counter
    import ptc_pkg::*;
#(
    parameter int W = CNT_W
)(
    input  wire logic         sys_clk,      // system clock
    input  wire logic         rstSyncB,     // synced reset, low active
    input  wire logic         tick,         // count clock enable
    input  wire logic         runWr,        // run bit write strobe
    input  wire logic         runVal,       // run bit written value
    input  wire logic         clrWr,        // clear written as 1
    input  wire logic         oneshotSel,   // one-shot mode select
    input  wire logic         cmpBHit,      // compare b event on this counter
    output logic [W-1:0]      counterValue, // live count
    output logic              running       // run state
);
    logic         run_reg;
    logic [W-1:0] cnt_reg;

    assign counterValue = cnt_reg;
    assign running      = run_reg;

    always_ff @(posedge sys_clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
            run_reg <= 1'b0;
        else if (runWr)
            run_reg <= runVal;
        else if (oneshotSel && cmpBHit)
            run_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
            cnt_reg <= '0;
        else if (clrWr)
            cnt_reg <= '0;
        else if (run_reg && cmpBHit)
            cnt_reg <= '0;
        else if (run_reg && tick)
            cnt_reg <= cnt_reg + 1'b1;
    end
endmodule
`default_nettype wire

// ### rtl/ptc_pkg.sv
// package for the four-channel compare/capture pwm timer control block
// assumes a single sys_clk domain; shared by all design files
package ptc_pkg;
    localparam int NUM_CH        = 4;
    localparam int CNT_W         = 16;
    localparam int SEL_W         = 2;
    localparam int NUM_CAUSE     = 6;
    localparam logic [1:0] GEN_OFF      = 2'h0;
    localparam logic [1:0] GEN_RISEFALL = 2'h1;
    localparam logic [1:0] GEN_TOGA     = 2'h2;
    localparam logic [1:0] GEN_TOGB     = 2'h3;
    localparam logic [1:0] SEL_RST      = 2'h0;
    localparam logic [15:0] CNT_RST     = 16'h0000;
    // interrupt flag bit positions
    localparam int IF_CMPA   = 0;
    localparam int IF_CMPB   = 1;
    localparam int IF_CAPA   = 2;
    localparam int IF_CAPB   = 3;
    localparam int IF_CAPAOW = 4;
    localparam int IF_CAPBOW = 5;
endpackage

// ### rtl/ptc_timer.sv
// four-channel compare/capture pwm timer control, counters, waves, flags
// assumes control ports are synchronous to sys_clk; write strobes are one cycle
`timescale 1ns/1ps
`default_nettype none
module ptc_timer
    import ptc_pkg::*;
#(
    parameter int N = NUM_CH,
    parameter int W = CNT_W
)(
    input  wire logic                  sys_clk,           // system clock 25 MHz
    input  wire logic                  rst_b,             // async reset, low active
    input  wire logic [N-1:0]          countTick,         // per-channel count clock enable
    input  wire logic                  sharedCounterMode, // counters share channel 0 clock
    input  wire logic [N-1:0]          oneshotSelect,     // one-shot per counter
    input  wire logic [N*SEL_W-1:0]    counterSelectIn,   // counter select write data
    input  wire logic [N-1:0]          counterSelectWr,   // counter select write strobe
    input  wire logic [N-1:0]          countRunWr,        // run bit write strobe
    input  wire logic [N-1:0]          countRunVal,       // run bit value
    input  wire logic [N-1:0]          counterClearWr,    // clear written as 1
    input  wire logic [N-1:0]          capModeA,          // register a in capture mode
    input  wire logic [N-1:0]          capModeB,          // register b in capture mode
    input  wire logic [N*W-1:0]        compareA,          // compare a values
    input  wire logic [N*W-1:0]        compareB,          // compare b values
    input  wire logic [N-1:0]          captureTrigA,      // capture a trigger pulse
    input  wire logic [N-1:0]          captureTrigB,      // capture b trigger pulse
    input  wire logic [2*N-1:0]        waveAGenMode,      // wave a mode per channel
    input  wire logic [2*N-1:0]        waveBGenMode,      // wave b mode per channel
    input  wire logic [N-1:0]          waveAInvert,       // wave a polarity
    input  wire logic [N-1:0]          waveBInvert,       // wave b polarity
    input  wire logic [N*NUM_CAUSE-1:0] irqEnable,        // cause enables
    input  wire logic [N*NUM_CAUSE-1:0] irqFlagClearWr,   // write one to clear flag
    output logic [N*W-1:0]             counterValue,      // registered counter readback
    output logic [N*W-1:0]             captureA,          // capture a data
    output logic [N*W-1:0]             captureB,          // capture b data
    output logic [N*SEL_W-1:0]         counterSelect,     // select fields readback
    output logic [N*NUM_CAUSE-1:0]     irqFlags,          // interrupt flags
    output logic [N-1:0]               irqRequest,        // one request per channel
    output logic [N-1:0]               countRunning,      // run state per counter
    output logic [2*N-1:0]             timerWaveOut       // pins: a at 2c, b at 2c+1
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rstMeta_reg;
    logic rstSyncB;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstMeta_reg <= 1'b0;
            rstSyncB    <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstSyncB    <= rstMeta_reg;
        end
    end

    // ------------------------------------------------------------
    // counter select fields
    // ------------------------------------------------------------
    logic [N*SEL_W-1:0] sel_reg;

    always_ff @(posedge sys_clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
            sel_reg <= {N{SEL_RST}};
        else
            for (int c = 0; c < N; c++)
                if (counterSelectWr[c])
                    sel_reg[c*SEL_W +: SEL_W] <= counterSelectIn[c*SEL_W +: SEL_W];
    end

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    logic [W-1:0] cnt     [N];
    logic [N-1:0] cntRun;
    logic [N-1:0] tickSel;
    logic [N-1:0] cntCmpB;
    logic [N-1:0] hitA;
    logic [N-1:0] hitB;
    logic [N-1:0] clrCh;

    function automatic logic [SEL_W-1:0] selOf(input logic [N*SEL_W-1:0] s, input int c);
        selOf = s[c*SEL_W +: SEL_W];
    endfunction

    // shared mode fans out channel 0 clock
    always_comb
    begin
        for (int k = 0; k < N; k++)
            tickSel[k] = sharedCounterMode ? countTick[0] : countTick[k];
    end

    // compare match per block on its selected counter
    always_comb
    begin
        for (int c = 0; c < N; c++)
        begin
            hitA[c] = !capModeA[c] && cntRun[selOf(sel_reg, c)]
                      && (cnt[selOf(sel_reg, c)] == compareA[c*W +: W]);
            hitB[c] = !capModeB[c] && cntRun[selOf(sel_reg, c)]
                      && (cnt[selOf(sel_reg, c)] == compareB[c*W +: W]);
        end
    end

    // a counter resets on compare b of any block that uses it
    always_comb
    begin
        cntCmpB = '0;
        clrCh   = '0;                 // zeroed up front: a later k must not undo an earlier hit
        for (int k = 0; k < N; k++)
        begin
            for (int c = 0; c < N; c++)
            begin
                if (hitB[c] && selOf(sel_reg, c) == SEL_W'(k))
                    cntCmpB[k] = 1'b1;
                if (counterClearWr[k] && selOf(sel_reg, c) == SEL_W'(k))
                    clrCh[c] = 1'b1;
            end
        end
    end

    for (genvar k = 0; k < N; k++)
    begin : g_cnt
        ptc_counter #(.W(W)) u_cnt (
            .sys_clk      (sys_clk),
            .rstSyncB     (rstSyncB),
            .tick         (tickSel[k]),
            .runWr        (countRunWr[k]),
            .runVal       (countRunVal[k]),
            .clrWr        (counterClearWr[k]),
            .oneshotSel   (oneshotSelect[k]),
            .cmpBHit      (cntCmpB[k]),
            .counterValue (cnt[k]),
            .running      (cntRun[k])
        );
    end

    // ------------------------------------------------------------
    // waveform outputs
    // ------------------------------------------------------------
    for (genvar c = 0; c < N; c++)
    begin : g_wave
        ptc_wave u_wa (
            .sys_clk  (sys_clk),
            .rstSyncB (rstSyncB),
            .genMode  (waveAGenMode[2*c +: 2]),
            .invert   (waveAInvert[c]),
            .cmpA     (hitA[c]),
            .cmpB     (hitB[c]),
            .clr      (clrCh[c]),
            .capMode  (capModeA[c] | capModeB[c]),
            .waveOut  (timerWaveOut[2*c])
        );
        ptc_wave u_wb (
            .sys_clk  (sys_clk),
            .rstSyncB (rstSyncB),
            .genMode  (waveBGenMode[2*c +: 2]),
            .invert   (waveBInvert[c]),
            .cmpA     (hitA[c]),
            .cmpB     (hitB[c]),
            .clr      (clrCh[c]),
            .capMode  (capModeA[c] | capModeB[c]),
            .waveOut  (timerWaveOut[2*c+1])
        );
    end

    // ------------------------------------------------------------
    // capture registers
    // ------------------------------------------------------------
    logic [N-1:0] capHitA;
    logic [N-1:0] capHitB;

    always_comb
    begin
        for (int c = 0; c < N; c++)
        begin
            capHitA[c] = capModeA[c] && captureTrigA[c] && cntRun[selOf(sel_reg, c)];
            capHitB[c] = capModeB[c] && captureTrigB[c] && cntRun[selOf(sel_reg, c)];
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
        begin
            captureA <= '0;
            captureB <= '0;
        end
        else
            for (int c = 0; c < N; c++)
            begin
                if (capHitA[c])
                    captureA[c*W +: W] <= cnt[selOf(sel_reg, c)];
                if (capHitB[c])
                    captureB[c*W +: W] <= cnt[selOf(sel_reg, c)];
            end
    end

    // ------------------------------------------------------------
    // interrupt flags, set wins over clear
    // ------------------------------------------------------------
    logic [N*NUM_CAUSE-1:0] flagSet;
    logic [N*NUM_CAUSE-1:0] flagNext;

    always_comb
    begin
        for (int c = 0; c < N; c++)
        begin
            flagSet[c*NUM_CAUSE + IF_CMPA]   = hitA[c];
            flagSet[c*NUM_CAUSE + IF_CMPB]   = hitB[c];
            flagSet[c*NUM_CAUSE + IF_CAPA]   = capHitA[c];
            flagSet[c*NUM_CAUSE + IF_CAPB]   = capHitB[c];
            flagSet[c*NUM_CAUSE + IF_CAPAOW] = capHitA[c] && irqFlags[c*NUM_CAUSE + IF_CAPA];
            flagSet[c*NUM_CAUSE + IF_CAPBOW] = capHitB[c] && irqFlags[c*NUM_CAUSE + IF_CAPB];
        end
        flagNext = (irqFlags & ~irqFlagClearWr) | flagSet;
    end

    always_ff @(posedge sys_clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
            irqFlags <= '0;
        else
            irqFlags <= flagNext;
    end

    always_ff @(posedge sys_clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
            irqRequest <= '0;
        else
            for (int c = 0; c < N; c++)
                irqRequest[c] <= |(flagNext[c*NUM_CAUSE +: NUM_CAUSE]
                                   & irqEnable[c*NUM_CAUSE +: NUM_CAUSE]);
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
        begin
            counterValue  <= '0;
            counterSelect <= '0;
            countRunning  <= '0;
        end
        else
        begin
            for (int k = 0; k < N; k++)
                counterValue[k*W +: W] <= cnt[k];
            counterSelect <= sel_reg;
            countRunning  <= cntRun;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_clrRun;
        countRunWr[0] && countRunVal[0] && counterClearWr[0];
    endsequence

    chk_clear_zero: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        counterClearWr[0] |=> cnt[0] == '0)
        else $error("counter not zero after clear");
    chk_clear_then_run: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        s_clrRun |=> cnt[0] == '0 && cntRun[0])
        else $error("clear with run did not clear and start");
    chk_stop_hold: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        !cntRun[0] && !counterClearWr[0] |=> cnt[0] == $past(cnt[0]))
        else $error("stopped counter changed");
    chk_count_step: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        cntRun[0] && tickSel[0] && !cntCmpB[0] && !counterClearWr[0]
        |=> cnt[0] == W'($past(cnt[0]) + 1'b1))
        else $error("counter did not advance by one");
    chk_cmpb_reset: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        cntCmpB[0] && !counterClearWr[0] |=> cnt[0] == '0)
        else $error("compare b did not reset counter");
    for (genvar k = 0; k < N; k++)
    begin : g_chk_oneshot
        chk_oneshot_stop: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
            oneshotSelect[k] && cntCmpB[k] && !countRunWr[k] |=> !cntRun[k])
            else $error("one-shot counter kept running");
    end
    chk_repeat_run: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        cntRun[0] && !oneshotSelect[0] && !countRunWr[0] |=> cntRun[0])
        else $error("repeat counter stopped by itself");
    chk_shared_tick: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        sharedCounterMode |-> tickSel == {N{countTick[0]}})
        else $error("shared mode not on channel 0 clock");
    chk_flag_set: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        hitB[0] |=> irqFlags[IF_CMPB])
        else $error("compare b flag lost");
    chk_irq_merge: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        irqRequest[0] == |(irqFlags[NUM_CAUSE-1:0] & $past(irqEnable[NUM_CAUSE-1:0])))
        else $error("request does not match flags");
    chk_cap_no_wave: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        capModeA[0] ##1 capModeA[0] |-> timerWaveOut[0] == $past(waveAInvert[0]))
        else $error("capture mode channel drives a waveform");
    chk_clear_wave: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        clrCh[0] |=> timerWaveOut[1:0] == {$past(waveBInvert[0]), $past(waveAInvert[0])})
        else $error("clear left a waveform active");

    sequence s_togBEvent;
        waveAGenMode[1:0] == GEN_TOGB && hitB[0] && !clrCh[0] && !capModeA[0]
            && $stable(waveAInvert[0]);
    endsequence
    chk_toggle_b: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
        s_togBEvent |=> timerWaveOut[0] != $past(timerWaveOut[0]))
        else $error("toggle-on-b output did not toggle");
endmodule
`default_nettype wire

// ### rtl/ptc_wave.sv
// one waveform output generator with mode and polarity
// assumes compare events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module ptc_wave
    import ptc_pkg::*;
(
    input  wire logic       sys_clk,   // system clock
    input  wire logic       rstSyncB,  // synced reset, low active
    input  wire logic [1:0] genMode,   // generation mode
    input  wire logic       invert,    // polarity invert
    input  wire logic       cmpA,      // compare a event
    input  wire logic       cmpB,      // compare b event
    input  wire logic       clr,       // counter clear
    input  wire logic       capMode,   // channel in capture mode
    output logic            waveOut    // pin level, registered
);
    logic act_reg;
    logic actNext;

    always_comb
    begin
        actNext = act_reg;
        unique case (genMode)
            GEN_OFF:      actNext = 1'b0;
            GEN_RISEFALL: actNext = cmpB ? 1'b0 : (cmpA ? 1'b1 : act_reg);
            GEN_TOGA:     actNext = cmpA ? ~act_reg : act_reg;
            GEN_TOGB:     actNext = cmpB ? ~act_reg : act_reg;
        endcase
        if (clr || capMode)
            actNext = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
            act_reg <= 1'b0;
        else
            act_reg <= actNext;
    end

    always_ff @(posedge sys_clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
            waveOut <= 1'b0;
        else
            waveOut <= actNext ^ invert;
    end
endmodule
`default_nettype wire

// ### verif/ptc_far_model.sv
// far-side model: per-channel count clock source and interrupt collector
// assumes sys_clk is the block's clock; enables change just after an edge
`timescale 1ns/1ps
`default_nettype none
module ptc_far_model
    import ptc_pkg::*;
(
    input  wire logic [NUM_CH-1:0] tickEn,     // count clock wanted per channel
    input  wire logic              sys_clk,    // system clock
    input  wire logic [NUM_CH-1:0] irqRequest, // request lines from the block
    output var  logic [NUM_CH-1:0] countTick,  // count clock enables
    output var  logic [NUM_CH-1:0] irqSeen     // sticky record of requests
);
    initial
    begin
        countTick = '0;
        irqSeen   = '0;
    end
    // each channel has its own count clock source
    always @(posedge sys_clk)
    begin
        countTick <= #1 tickEn;
        irqSeen   <= #1 irqSeen | irqRequest;
    end
endmodule
`default_nettype wire

// ### verif/test_pwm_timer_counter_control.sv
// self-checking bench for the four-channel pwm timer control block
// assumes the far-side model supplies count clocks and collects requests
`timescale 1ns/1ps
`default_nettype none
module test_pwm_timer_counter_control;
    import ptc_pkg::*;
    logic                        sys_clk, rst_b, sharedCounterMode;
    logic [NUM_CH-1:0]           tickEn, countTick, irqSeen, oneshotSelect;
    logic [NUM_CH-1:0]           counterSelectWr, countRunWr, countRunVal, counterClearWr;
    logic [NUM_CH-1:0]           capModeA, capModeB, captureTrigA, captureTrigB;
    logic [NUM_CH-1:0]           waveAInvert, waveBInvert, irqRequest, countRunning;
    logic [NUM_CH*SEL_W-1:0]     counterSelectIn, counterSelect;
    logic [NUM_CH*CNT_W-1:0]     compareA, compareB, counterValue, captureA, captureB;
    logic [2*NUM_CH-1:0]         waveAGenMode, waveBGenMode, timerWaveOut;
    logic [NUM_CH*NUM_CAUSE-1:0] irqEnable, irqFlagClearWr, irqFlags;
    logic [1:0]                  prev;
    int                          fails, tests_run, cyc;
    logic [31:0]                 a, h, sumA, sumB;
    int                          expSum[4] = '{0, 20, 6, 14};

    ptc_timer ptc_timer_i (
        .sys_clk, .rst_b, .countTick, .sharedCounterMode, .oneshotSelect,
        .counterSelectIn, .counterSelectWr, .countRunWr, .countRunVal, .counterClearWr,
        .capModeA, .capModeB, .compareA, .compareB, .captureTrigA, .captureTrigB,
        .waveAGenMode, .waveBGenMode, .waveAInvert, .waveBInvert, .irqEnable,
        .irqFlagClearWr, .counterValue, .captureA, .captureB, .counterSelect,
        .irqFlags, .irqRequest, .countRunning, .timerWaveOut);
    ptc_far_model ptc_far_model_i (.tickEn, .sys_clk, .irqRequest, .countTick, .irqSeen);

    // ----------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    // whole-word counter read, never two halves
    function automatic logic [15:0] cv(input int c);
        return counterValue[c*CNT_W +: CNT_W];
    endfunction
    // one-cycle write of run and clear bits of counter c
    task automatic ctl(input int c, input logic run, input logic val, input logic clr);
        countRunWr[c]     = run;
        countRunVal[c]    = val;
        counterClearWr[c] = clr;
        step(1);
        countRunWr[c]     = 1'b0;
        counterClearWr[c] = 1'b0;
    endtask

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial
    begin
        rst_b = 1'b0; tickEn = 4'hf; sharedCounterMode = 1'b0; oneshotSelect = 4'h0;
        counterSelectIn = 8'h00; counterSelectWr = 4'h0; countRunWr = 4'h0;
        countRunVal = 4'h0; counterClearWr = 4'h0; capModeA = 4'h0; capModeB = 4'h0;
        compareA = '1; compareB = '1; captureTrigA = 4'h0; captureTrigB = 4'h0;
        waveAGenMode = 8'h00; waveBGenMode = 8'h00; waveAInvert = 4'h0;
        waveBInvert = 4'h0; irqEnable = '0; irqFlagClearWr = '0;
        step(4);
        rst_b = 1'b1;
        step(3);
        chk(counterSelect, 8'h00, "select reset");
        chk(timerWaveOut, 8'h00, "wave reset");
        for (int s = 0; s < 4; s++)
        begin
            counterSelectIn[3:2] = s[1:0];
            counterSelectWr[1] = 1'b1;
            step(1);
            counterSelectWr[1] = 1'b0;
            step(2);
            chk(counterSelect[3:2], s[1:0], "select field");
        end
        counterSelectIn = 8'he4;
        counterSelectWr = 4'hf;
        step(1);
        counterSelectWr = 4'h0;
        step(2);
        chk(counterSelect, 8'he4, "own selects");
        // counter 1: clear with run, halt, resume, clear
        ctl(1, 1'b1, 1'b1, 1'b1);
        step(1);
        chk(cv(1), 16'h0, "clear with run");
        step(4);
        chk(cv(1), 16'h4, "count step");
        ctl(1, 1'b1, 1'b0, 1'b0);
        step(3);
        h = cv(1);
        step(5);
        chk(cv(1), h[15:0], "halted");
        ctl(1, 1'b1, 1'b1, 1'b0);
        step(3);
        a = cv(1);
        chk(a, h + 2, "resume from held");
        step(5);
        chk(cv(1), 16'(a + 5), "resumed");
        ctl(1, 1'b0, 1'b0, 1'b1);
        step(1);
        chk(cv(1), 16'h0, "clear");
        // counter 3 on the shared clock, then on its own stopped clock
        tickEn = 4'h7;
        sharedCounterMode = 1'b1;
        ctl(3, 1'b1, 1'b1, 1'b1);
        step(3);
        a = cv(3);
        step(6);
        chk(cv(3), 16'(a + 6), "shared clock");
        sharedCounterMode = 1'b0;
        step(3);
        a = cv(3);
        step(6);
        chk(cv(3), a[15:0], "own clock");
        tickEn = 4'hf;
        // counter 2 one-shot
        oneshotSelect[2] = 1'b1;
        compareB[47:32] = 16'h5;
        ctl(2, 1'b1, 1'b1, 1'b1);
        step(20);
        chk(countRunning[2], 1'b0, "one-shot stop");
        chk(irqFlags[13], 1'b1, "compare b flag");
        a = cv(2);
        step(4);
        chk(cv(2), a[15:0], "one-shot held");
        // channel 0 pwm, configured before start
        compareA[15:0] = 16'h3;
        compareB[15:0] = 16'h7;
        irqEnable[1] = 1'b1;
        ctl(0, 1'b1, 1'b1, 1'b1);
        step(20);
        chk(countRunning[0], 1'b1, "repeat runs on");
        chk(irqRequest[0], 1'b1, "merged request");
        for (int m = 0; m < 4; m++)
        begin
            waveAGenMode[1:0] = m[1:0];
            waveBGenMode[1:0] = 2'(3 - m);
            step(10);
            prev = timerWaveOut[1:0];
            sumA = 0;
            sumB = 0;
            for (int k = 0; k < 16; k++)
            begin
                step(1);
                if (timerWaveOut[0] !== prev[0]) sumA += cv(0);
                if (timerWaveOut[1] !== prev[1]) sumB += cv(0);
                prev = timerWaveOut[1:0];
            end
            chk(sumA, expSum[m], "wave a edges");
            chk(sumB, expSum[3 - m], "wave b edges");
        end
        // capture mode on block 0
        capModeA[0] = 1'b1;
        capModeB[0] = 1'b1;
        step(3);
        sumA = 0;
        for (int k = 0; k < 12; k++)
        begin
            step(1);
            sumA += timerWaveOut[1:0];
        end
        chk(sumA, 0, "capture waves");
        repeat (2)
        begin
            captureTrigA[0] = 1'b1;
            captureTrigB[0] = 1'b1;
            step(1);
            h = cv(0);
            captureTrigA[0] = 1'b0;
            captureTrigB[0] = 1'b0;
            step(2);
        end
        chk(irqFlags[5:2], 4'hf, "capture flags");
        chk(captureA[15:0], h[15:0], "capture a data");
        chk(captureB[15:0], h[15:0], "capture b data");
        capModeA[0] = 1'b0;
        capModeB[0] = 1'b0;
        waveAGenMode[1:0] = GEN_RISEFALL;
        ctl(0, 1'b1, 1'b1, 1'b1);
        step(5);
        chk(timerWaveOut[1:0], 2'h1, "wave a risen");
        waveAInvert[0] = 1'b1;
        waveBInvert[0] = 1'b1;
        ctl(0, 1'b1, 1'b0, 1'b1);
        chk(timerWaveOut[1:0], 2'h3, "cleared low-active");
        waveAInvert[0] = 1'b0;
        waveBInvert[0] = 1'b0;
        step(3);
        chk(timerWaveOut[1:0], 2'h0, "high-active idle");
        irqFlagClearWr[5:0] = 6'h3f;
        step(1);
        irqFlagClearWr[5:0] = 6'h00;
        step(2);
        chk(irqFlags[5:0], 6'h00, "flags cleared");
        chk(irqRequest[0], 1'b0, "request dropped");
        chk(irqSeen[0], 1'b1, "request seen");
        end_sim();
    end
endmodule
`default_nettype wire
